// [include/bsh_map.svh]
// Constants of the bin sort handler port
`ifndef BSH_MAP_SVH
`define BSH_MAP_SVH
`define BSH_CLK_MHZ          20
`define BSH_TRIG_MIN_NS      1000
`define BSH_TRIG_FILT_CYC    ((`BSH_TRIG_MIN_NS * `BSH_CLK_MHZ) / 2000)
`define BSH_BIN_COUNT        10
`define BSH_BIN_IDX_W        4
`define BSH_RESULT_IDLE_N    10'h3FF
`endif

// [include/bsh_pkg.sv]
// Types of the bin sort handler port
package bsh_pkg;
  typedef enum logic [1:0] {
    BSH_IDLE    = 2'b00,
    BSH_MEASURE = 2'b01,
    BSH_COMPARE = 2'b10,
    BSH_DONE    = 2'b11
  } bsh_state_t;
  typedef logic [3:0] bsh_bin_t;
endpackage : bsh_pkg

// [include/bsh_sync_if.sv]
// Synchronised handler inputs carried from filter to main logic
`timescale 1ns/1ps
interface bsh_sync_if;
  logic trig_rise;
  logic key_lock;
  modport src (output trig_rise, output key_lock);
  modport dst (input  trig_rise, input  key_lock);
endinterface : bsh_sync_if

// [hw/bsh_input_filter.sv]
// Synchroniser for trigger and key-lock inputs, glitch filter for the trigger only
`timescale 1ns/1ps
`include "bsh_map.svh"
module bsh_input_filter (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  external_trigger_n,
  input  wire logic  key_lock_n,
  bsh_sync_if.src    sync
);
  import bsh_pkg::*;
  localparam int FILT = `BSH_TRIG_FILT_CYC;
  logic [1:0] trig_s_r;
  logic [1:0] lock_s_r;
  logic [5:0] filt_cnt_r;
  logic       trig_lvl_r;
  logic       rise_r;

  // Two-stage synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_s_r <= 2'h3;
      lock_s_r <= 2'h3;
    end else begin
      trig_s_r <= {trig_s_r[0], external_trigger_n};
      lock_s_r <= {lock_s_r[0], key_lock_n};
    end
  end

  // Filtered trigger level, changes only after a stable run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_cnt_r <= 6'h00;
      trig_lvl_r <= 1'b1;
      rise_r     <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (trig_s_r[1] == trig_lvl_r) begin
        filt_cnt_r <= 6'h00;
      end else if (filt_cnt_r == 6'(FILT - 1)) begin
        filt_cnt_r <= 6'h00;
        trig_lvl_r <= trig_s_r[1];
        rise_r     <= trig_s_r[1];
      end else begin
        filt_cnt_r <= filt_cnt_r + 6'h01;
      end
    end
  end

  assign sync.trig_rise = rise_r;
  assign sync.key_lock  = ~lock_s_r[1];

  property p_filter_len;
    @(posedge clk) disable iff (rst)
      $rose(rise_r) |-> $past(trig_s_r[1], 1) && $past(trig_s_r[1], 9);
  endproperty
  a_filter_len: assert property (p_filter_len) else $error("trigger accepted without stable run");
endmodule : bsh_input_filter

// [hw/bsh_handler_port.sv]
// Handler port: bin result outputs, handshake outputs, trigger and key lock
`timescale 1ns/1ps
`include "bsh_map.svh"
// Overview of operation
// - Every result, handshake and alarm output is active low; test_start and key_accept are active high.
// - Ten bin outputs; only the sorted bin is asserted.
// - Pass asserted whenever the result lies in any bin.
// - Fail asserted whenever the result lies in no bin.
// - Contact-check fail output follows the contact check result.
// - Open/short fail output reports the on-off test result.
// - Analog-done asserted when analog measurement ends; next part may load.
// - Results are not valid on analog-done alone; handler waits for complete.
// - Measurement-complete asserted only when data and compare results are stable.
// - In single trigger mode a trigger rising edge starts one test only while idle or done; edges during a test are ignored.
// - Key lock active blocks all front panel keys on key_press.
// - Alarm asserted on transient power failure or interface board reset.
module bsh_handler_port (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            external_trigger_n,
  input  wire logic            key_lock_n,
  input  wire logic            trig_single_mode,
  input  wire logic            analog_done,
  input  wire logic            compare_valid,
  input  wire bsh_pkg::bsh_bin_t result_bin,
  input  wire logic            result_in_bin,
  input  wire logic            contact_fail,
  input  wire logic            open_short_fail,
  input  wire logic            power_fail,
  input  wire logic            key_press,
  output logic                 test_start,
  output logic                 key_accept,
  output logic [9:0]           sort_bin_n,
  output logic                 pass_n,
  output logic                 fail_n,
  output logic                 contact_fail_n,
  output logic                 open_short_fail_n,
  output logic                 analog_done_n,
  output logic                 measure_complete_n,
  output logic                 alarm_n
);
  import bsh_pkg::*;

  bsh_sync_if  sync ();
  bsh_state_t  state_r;
  logic [1:0]  pf_s_r;
  logic        alarm_hold_r;

  // ------------------------------------------------------------
  // Input conditioning
  // ------------------------------------------------------------
  bsh_input_filter u_filter (
    .clk                (clk),
    .rst                (rst),
    .external_trigger_n (external_trigger_n),
    .key_lock_n         (key_lock_n),
    .sync               (sync)
  );

  // Decode a bin index into an active-low one-hot
  function automatic logic [9:0] bin_decode_n(input bsh_bin_t b, input logic hit);
    logic [9:0] v;
    v = `BSH_RESULT_IDLE_N;
    if (hit && b < 4'(`BSH_BIN_COUNT)) begin
      v[b] = 1'b0;
    end
    return v;
  endfunction : bin_decode_n

  // ------------------------------------------------------------
  // Test sequencing
  // ------------------------------------------------------------
  // Measurement sequence state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= BSH_IDLE;
    end else begin
      case (state_r)
        BSH_IDLE:    if (trig_single_mode && sync.trig_rise) state_r <= BSH_MEASURE;
        BSH_MEASURE: if (analog_done)   state_r <= BSH_COMPARE;
        BSH_COMPARE: if (compare_valid) state_r <= BSH_DONE;
        BSH_DONE:    if (trig_single_mode && sync.trig_rise) state_r <= BSH_MEASURE;
        default:     state_r <= BSH_IDLE;
      endcase
    end
  end

  // Start pulse and key acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_start <= 1'b0;
      key_accept <= 1'b0;
    end else begin
      test_start <= trig_single_mode && sync.trig_rise &&
                    (state_r == BSH_IDLE || state_r == BSH_DONE);
      key_accept <= key_press && !sync.key_lock;
    end
  end

  // ------------------------------------------------------------
  // Result outputs, latched when compare finishes
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sort_bin_n        <= `BSH_RESULT_IDLE_N;
      pass_n            <= 1'b1;
      fail_n            <= 1'b1;
      contact_fail_n    <= 1'b1;
      open_short_fail_n <= 1'b1;
    end else if (state_r == BSH_MEASURE && analog_done) begin
      sort_bin_n        <= `BSH_RESULT_IDLE_N;
      pass_n            <= 1'b1;
      fail_n            <= 1'b1;
      contact_fail_n    <= 1'b1;
      open_short_fail_n <= 1'b1;
    end else if (state_r == BSH_COMPARE && compare_valid) begin
      sort_bin_n        <= bin_decode_n(result_bin, result_in_bin);
      pass_n            <= ~result_in_bin;
      fail_n            <= result_in_bin;
      contact_fail_n    <= ~contact_fail;
      open_short_fail_n <= ~open_short_fail;
    end
  end

  // ------------------------------------------------------------
  // Handshake outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analog_done_n      <= 1'b1;
      measure_complete_n <= 1'b1;
    end else begin
      // Analog done wins over the start-of-test clear in the same cycle
      if (state_r == BSH_MEASURE && analog_done) begin
        analog_done_n <= 1'b0;
      end else if (test_start) begin
        analog_done_n <= 1'b1;
      end
      // Start pulse only occurs in MEASURE, so this also clears it on a new test
      measure_complete_n <= (state_r != BSH_DONE);
    end
  end

  // Alarm: power fail synchronised, also held low during board reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_s_r       <= 2'h0;
      alarm_hold_r <= 1'b1;
      alarm_n      <= 1'b0;
    end else begin
      pf_s_r       <= {pf_s_r[0], power_fail};
      alarm_hold_r <= 1'b0;
      alarm_n      <= !(pf_s_r[1] || alarm_hold_r);
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pass_fail_excl;
    @(posedge clk) disable iff (rst) !measure_complete_n |-> (pass_n != fail_n);
  endproperty
  a_pass_fail_excl: assert property (p_pass_fail_excl) else $error("pass and fail not exclusive");

  property p_fail_no_bin;
    @(posedge clk) disable iff (rst) (!fail_n && !measure_complete_n) |-> (sort_bin_n == 10'h3FF);
  endproperty
  a_fail_no_bin: assert property (p_fail_no_bin) else $error("bin asserted with fail");

  property p_one_bin;
    @(posedge clk) disable iff (rst) !pass_n |-> $onehot(~sort_bin_n);
  endproperty
  a_one_bin: assert property (p_one_bin) else $error("pass without exactly one bin");

  property p_eom_after_index;
    @(posedge clk) disable iff (rst) $fell(measure_complete_n) |-> !analog_done_n;
  endproperty
  a_eom_after_index: assert property (p_eom_after_index) else $error("complete before analog done");

  property p_results_stable;
    @(posedge clk) disable iff (rst) (!measure_complete_n && $past(!measure_complete_n)) |->
      $stable(sort_bin_n) && $stable(pass_n) && $stable(fail_n) &&
      $stable(contact_fail_n) && $stable(open_short_fail_n);
  endproperty
  a_results_stable: assert property (p_results_stable) else $error("results moved while complete");

  property p_index_timing;
    @(posedge clk) disable iff (rst) (state_r == BSH_MEASURE && analog_done) |=> !analog_done_n;
  endproperty
  a_index_timing: assert property (p_index_timing) else $error("analog done not asserted");

  property p_trig_start;
    @(posedge clk) disable iff (rst)
      (sync.trig_rise && trig_single_mode && (state_r == BSH_IDLE || state_r == BSH_DONE)) |=>
        test_start && (state_r == BSH_MEASURE);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger edge did not start test");

  property p_key_lock;
    @(posedge clk) disable iff (rst) $past(sync.key_lock) |-> !key_accept;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("key accepted while locked");

  property p_alarm;
    @(posedge clk) disable iff (rst) $rose(pf_s_r[1]) |=> !alarm_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing on power fail");

  property p_start_pulse;
    @(posedge clk) disable iff (rst) test_start |=> !test_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse longer than one cycle");

  property p_mode_off;
    @(posedge clk) disable iff (rst) (sync.trig_rise && !trig_single_mode) |=> !test_start;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("test started with single mode off");

  property p_busy_refuse;
    @(posedge clk) disable iff (rst)
      (sync.trig_rise && (state_r == BSH_MEASURE || state_r == BSH_COMPARE)) |=> !test_start;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("test started while busy");

  property p_clear_on_index;
    @(posedge clk) disable iff (rst) (state_r == BSH_MEASURE && analog_done) |=>
      (sort_bin_n == `BSH_RESULT_IDLE_N) && pass_n && fail_n && measure_complete_n;
  endproperty
  a_clear_on_index: assert property (p_clear_on_index) else $error("results shown on analog done");
endmodule : bsh_handler_port

// [bench/bsh_handler_model.sv]
// Handler side model: fires triggers and samples results on measure complete
`timescale 1ns/1ps
module bsh_handler_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic       measure_complete_n,
  input  wire logic [9:0] sort_bin_n,
  output logic            external_trigger_n,
  output logic [9:0]      seen_bins
);
  // Trigger held low 24 cycles (1.2 us) so the rise is well qualified
  initial begin
    external_trigger_n = 1'b1;
    forever begin
      @(posedge fire);
      @(negedge clk);
      external_trigger_n = 1'b0;
      repeat (24) @(negedge clk);
      external_trigger_n = 1'b1;
    end
  end
  // Results are taken only when measure complete falls
  always @(negedge measure_complete_n) begin
    seen_bins = sort_bin_n;
  end
endmodule : bsh_handler_model

// [bench/testbench.sv]
// Self-checking bench for the bin sort handler port
`timescale 1ns/1ps
module testbench;
  import bsh_pkg::*;
  logic       clk, rst, key_lock_n, trig_single_mode, analog_done, compare_valid, fire;
  logic       result_in_bin, contact_fail, open_short_fail, power_fail, key_press;
  bsh_bin_t   result_bin;
  logic       external_trigger_n, test_start, key_accept, pass_n, fail_n, contact_fail_n;
  logic       open_short_fail_n, analog_done_n, measure_complete_n, alarm_n, seen;
  logic [9:0] sort_bin_n, seen_bins;
  int         err_total, total_checks;

  bsh_handler_port uut (.clk(clk), .rst(rst), .external_trigger_n(external_trigger_n),
    .key_lock_n(key_lock_n), .trig_single_mode(trig_single_mode), .analog_done(analog_done),
    .compare_valid(compare_valid), .result_bin(result_bin), .result_in_bin(result_in_bin),
    .contact_fail(contact_fail), .open_short_fail(open_short_fail), .power_fail(power_fail),
    .key_press(key_press), .test_start(test_start), .key_accept(key_accept), .sort_bin_n(sort_bin_n),
    .pass_n(pass_n), .fail_n(fail_n), .contact_fail_n(contact_fail_n), .open_short_fail_n(open_short_fail_n),
    .analog_done_n(analog_done_n), .measure_complete_n(measure_complete_n), .alarm_n(alarm_n));
  bsh_handler_model partner (.clk(clk), .fire(fire), .measure_complete_n(measure_complete_n),
    .sort_bin_n(sort_bin_n), .external_trigger_n(external_trigger_n), .seen_bins(seen_bins));

  // Compare and report
  task chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Ask the handler for one trigger pulse, then look for test_start
  task trig_wait(input int lim, output logic got);
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    got = 1'b0;
    for (int i = 0; i < lim && got !== 1'b1; i++) begin
      @(negedge clk);
      got = test_start;
    end
  endtask : trig_wait
  // One full test; optional second trigger while measuring
  task run_test(input bsh_bin_t bin, input logic inb, input logic cf, input logic os, input logic busy);
    logic [9:0] exp;
    exp = inb ? ~(10'h001 << bin) : 10'h3FF;
    trig_wait(80, seen);
    chk("test_start", 10'h001, {9'h000, seen});
    if (busy) begin
      trig_wait(60, seen);
      chk("busy trigger", 10'h000, {9'h000, seen});
    end
    analog_done = 1'b1;
    @(negedge clk);
    analog_done = 1'b0;
    chk("analog_done_n", 10'h000, {9'h000, analog_done_n});
    chk("early complete", 10'h001, {9'h000, measure_complete_n});
    chk("bins cleared", 10'h3FF, sort_bin_n);
    result_bin = bin;
    result_in_bin = inb;
    contact_fail = cf;
    open_short_fail = os;
    compare_valid = 1'b1;
    @(negedge clk);
    compare_valid = 1'b0;
    @(negedge clk);
    chk("measure_complete_n", 10'h000, {9'h000, measure_complete_n});
    chk("sort_bin_n", exp, sort_bin_n);
    chk("pass_n", {9'h000, ~inb}, {9'h000, pass_n});
    chk("fail_n", {9'h000, inb}, {9'h000, fail_n});
    chk("contact_fail_n", {9'h000, ~cf}, {9'h000, contact_fail_n});
    chk("open_short_fail_n", {9'h000, ~os}, {9'h000, open_short_fail_n});
    chk("handler view", exp, seen_bins);
  endtask : run_test
  // One key press, watching key_accept for five cycles
  task key_try(output logic got);
    key_press = 1'b1;
    got = 1'b0;
    repeat (5) begin
      @(negedge clk);
      key_press = 1'b0;
      got = got | (key_accept === 1'b1);
    end
  endtask : key_try
  // Reset values, then the board-reset alarm through the first two edges after release
  task reset_test;
    chk("reset bins", 10'h3FF, sort_bin_n);
    chk("reset handshake", 10'h003, {8'h00, analog_done_n, measure_complete_n});
    chk("reset alarm", 10'h000, {9'h000, alarm_n});
    rst = 1'b0;
    @(negedge clk);
    chk("alarm first edge", 10'h000, {9'h000, alarm_n});
    @(negedge clk);
    chk("alarm release", 10'h001, {9'h000, alarm_n});
  endtask : reset_test
  // Trigger with single mode off must not start a test
  task mode_off_test;
    trig_single_mode = 1'b0;
    trig_wait(60, seen);
    chk("mode off trigger", 10'h000, {9'h000, seen});
    trig_single_mode = 1'b1;
  endtask : mode_off_test
  // Keys dropped while locked, passed once unlocked
  task key_lock_test;
    key_lock_n = 1'b0;
    repeat (4) @(negedge clk);
    key_try(seen);
    chk("locked key", 10'h000, {9'h000, seen});
    key_lock_n = 1'b1;
    repeat (4) @(negedge clk);
    key_try(seen);
    chk("unlocked key", 10'h001, {9'h000, seen});
  endtask : key_lock_test
  // Alarm on power failure, then on a board reset in mid-run
  task alarm_test;
    power_fail = 1'b1;
    repeat (5) @(negedge clk);
    chk("alarm on power fail", 10'h000, {9'h000, alarm_n});
    power_fail = 1'b0;
    repeat (5) @(negedge clk);
    chk("alarm cleared", 10'h001, {9'h000, alarm_n});
    rst = 1'b1;
    repeat (2) @(negedge clk);
    reset_test();
  endtask : alarm_test

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(20000 * 50);
    err_total++;
    end_sim();
  end
  // Main sequence, inputs change at the falling edge
  initial begin
    {rst, trig_single_mode, key_lock_n} = 3'b111;
    {analog_done, compare_valid, fire, result_in_bin, contact_fail} = 5'h00;
    {open_short_fail, power_fail, key_press} = 3'b000;
    result_bin = 4'h0;
    repeat (6) @(negedge clk);
    reset_test();
    for (int b = 0; b < 10; b++) run_test(b[3:0], 1'b1, b[0], b[1], b == 4);
    run_test(4'h3, 1'b0, 1'b1, 1'b1, 1'b0);
    mode_off_test();
    key_lock_test();
    alarm_test();
    end_sim();
  end
endmodule : testbench
